// >>> core/dacc_pair.sv
// Purpose: pair of dsp accumulators with 96-bit sign-extended view
// Assumes: requests come from execution logic on clk_sys, one per cycle
// Notes: read data is registered, one cycle after the request

`timescale 1ns/10ps

// Overview of operation
// RQ1: two independent accumulators, 72 stored bits each
// RQ2: each accumulator seen as 96 bits
// RQ3: reads of bits 95..72 copy bit 71
// RQ4: writes to bits 95..72 are dropped
// RQ5: multiply-class instructions overwrite the first accumulator
// RQ6: three writes load guard, high, low slices
// RQ7: four reads return guard, high, middle, low
// RQ8: slice write changes only its own slice
module dacc_pair
	import dacc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic wr_acc_sel,
	input wire dacc_wr_op_t wr_op,
	input wire logic [SLICE_W-1:0] wr_data,
	input wire logic rd_en,
	input wire logic rd_acc_sel,
	input wire dacc_rd_op_t rd_op,
	output logic [SLICE_W-1:0] rd_data,
	output logic rd_valid,
	input wire logic mul_en,
	input wire dacc_mul_op_t mul_op,
	input wire logic [ACC_STORED_W-1:0] mul_result,
	output logic [ACC_VIEW_W-1:0] acc_zero_view,
	output logic [ACC_VIEW_W-1:0] acc_one_view
);

	////////////////////////////////////////////////////////////////////
	// decoding helpers

	// widen stored bits to the 96-bit view with sign copies above
	function automatic logic [ACC_VIEW_W-1:0] sign_view(
		input logic [ACC_STORED_W-1:0] v
	);
		sign_view = {{EXT_W{v[SIGN_BIT]}}, v}; // RQ3
	endfunction : sign_view

	// pick the 32-bit window that a read instruction names
	function automatic logic [SLICE_W-1:0] pick_slice(
		input logic [ACC_VIEW_W-1:0] v,
		input dacc_rd_op_t op
	);
		logic [SLICE_W-1:0] s;
		s = RD_DATA_RESET;
		unique case (op)
			acc_guard_read_op: s = v[GUARD_LSB +: SLICE_W];
			acc_high_read_op: s = v[HIGH_LSB +: SLICE_W];
			acc_middle_read_op: s = v[MID_LSB +: SLICE_W]; // RQ7
			acc_low_read_op: s = v[LOW_LSB +: SLICE_W];
			default: s = RD_DATA_RESET;
		endcase
		pick_slice = s;
	endfunction : pick_slice

	// true for any instruction that replaces the first accumulator
	function automatic logic is_mul_class(input dacc_mul_op_t op);
		logic hit;
		hit = 1'b0;
		unique case (op)
			extended_signed_multiply_op,
			extended_unsigned_multiply_op,
			float_multiply_op,
			plain_multiply_op,
			repeat_multiply_accumulate_op: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		is_mul_class = hit;
	endfunction : is_mul_class

	////////////////////////////////////////////////////////////////////
	// storage slots

	logic [ACC_STORED_W-1:0] stored [ACC_COUNT];
	logic mul_load;

	// a multiply result and a slice write to slot zero in one cycle:
	// the multiply wins, since it retires the whole register
	assign mul_load = mul_en && is_mul_class(mul_op); // RQ5

	generate
		for (genvar i = 0; i < ACC_COUNT; i++) begin : g_acc
			dacc_store_if sif ();

			// slots are independent; only the selected one takes a write
			assign sif.wr_en = wr_en &&
				(wr_acc_sel == 1'(i)); // RQ1
			assign sif.wr_op = wr_op; // RQ6
			assign sif.wr_data = wr_data;
			assign sif.ld_en = (i == 0) ? mul_load : 1'b0; // RQ5
			assign sif.ld_data = mul_result;
			assign stored[i] = sif.value;

			dacc_store u_store (
				.clk_sys(clk_sys),
				.rst(rst),
				.port(sif.store)
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// full-width views for the dsp datapath, straight from storage

	assign acc_zero_view = sign_view(stored[0]); // RQ2
	assign acc_one_view = sign_view(stored[1]);

	////////////////////////////////////////////////////////////////////
	// slice read; sampled before any write of the same edge lands

	logic [SLICE_W-1:0] rd_data_r;
	logic [SLICE_W-1:0] rd_data_nxt;
	logic rd_valid_r;

	// view is rebuilt per read so guard bits always track bit 71
	always_comb begin
		rd_data_nxt = pick_slice(sign_view(stored[rd_acc_sel]),
			rd_op); // RQ7
	end

	// data holds until the next read request
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data_r <= RD_DATA_RESET;
		end else if (rd_en) begin
			rd_data_r <= rd_data_nxt; // RQ3
		end
	end

	// one-cycle strobe marking fresh read data
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_en;
		end
	end

	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;

endmodule : dacc_pair

// >>> core/dacc_pkg.sv
// Purpose: shared constants and types for the dsp accumulator pair
// Assumes: one core clock, asynchronous active-high reset
// Notes: widths are fixed; every slice position is named here once

package dacc_pkg;

	////////////////////////////////////////////////////////////////////
	// widths and slice positions
	localparam int ACC_COUNT = 2;
	localparam int ACC_STORED_W = 72;
	localparam int ACC_VIEW_W = 96;
	localparam int SLICE_W = 32;
	localparam int SIGN_BIT = 71;
	localparam int EXT_W = ACC_VIEW_W - ACC_STORED_W;
	localparam int GUARD_LSB = 64;
	localparam int HIGH_LSB = 32;
	localparam int MID_LSB = 16;
	localparam int LOW_LSB = 0;
	// only the low byte of a guard write lands in stored bits 71..64
	localparam int GUARD_STORED_W = ACC_STORED_W - GUARD_LSB;

	////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [ACC_STORED_W-1:0] ACC_RESET = 72'h0;
	localparam logic [SLICE_W-1:0] RD_DATA_RESET = 32'h0;

	////////////////////////////////////////////////////////////////////
	// slice write instructions
	typedef enum logic [2:0] {
		acc_guard_write_op = 3'h1,
		acc_high_write_op = 3'h2,
		acc_low_write_op = 3'h4
	} dacc_wr_op_t;

	// slice read instructions
	typedef enum logic [3:0] {
		acc_guard_read_op = 4'h1,
		acc_high_read_op = 4'h2,
		acc_middle_read_op = 4'h4,
		acc_low_read_op = 4'h8
	} dacc_rd_op_t;

	// multiply-class instructions that overwrite the first accumulator
	typedef enum logic [4:0] {
		extended_signed_multiply_op = 5'h01,
		extended_unsigned_multiply_op = 5'h02,
		float_multiply_op = 5'h04,
		plain_multiply_op = 5'h08,
		repeat_multiply_accumulate_op = 5'h10
	} dacc_mul_op_t;

endpackage : dacc_pkg

// >>> core/dacc_store.sv
// Purpose: one 72-bit accumulator slot with slice and full loads
// Assumes: caller never raises wr_en with an illegal op code
// Notes: full load beats a slice write in the same cycle

`timescale 1ns/10ps

module dacc_store
	import dacc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	dacc_store_if.store port
);

	logic [ACC_STORED_W-1:0] acc_r;

	assign port.value = acc_r;

	////////////////////////////////////////////////////////////////////
	// storage update; each slice write touches only its own bits
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			acc_r <= ACC_RESET;
		end else if (port.ld_en) begin
			acc_r <= port.ld_data; // RQ5
		end else if (port.wr_en) begin
			unique case (port.wr_op)
				acc_guard_write_op: begin
					// bits above 71 have no storage, so they fall away
					acc_r[ACC_STORED_W-1:GUARD_LSB] <=
						port.wr_data[GUARD_STORED_W-1:0]; // RQ4
				end
				acc_high_write_op: begin
					acc_r[HIGH_LSB +: SLICE_W] <= port.wr_data; // RQ6
				end
				acc_low_write_op: begin
					acc_r[LOW_LSB +: SLICE_W] <= port.wr_data; // RQ8
				end
				default: begin
					acc_r <= acc_r; // illegal code leaves contents alone
				end
			endcase
		end
	end

endmodule : dacc_store

// >>> core/dacc_store_if.sv
// Purpose: carrier between the accumulator pair and one storage slot
// Assumes: all signals on clk_sys
// Notes: the top drives the control side, the slot returns its contents

`timescale 1ns/10ps

interface dacc_store_if;
	import dacc_pkg::*;

	logic wr_en;
	dacc_wr_op_t wr_op;
	logic [SLICE_W-1:0] wr_data;
	logic ld_en;
	logic [ACC_STORED_W-1:0] ld_data;
	logic [ACC_STORED_W-1:0] value;

	modport ctrl (
		output wr_en,
		output wr_op,
		output wr_data,
		output ld_en,
		output ld_data,
		input value
	);

	modport store (
		input wr_en,
		input wr_op,
		input wr_data,
		input ld_en,
		input ld_data,
		output value
	);
endinterface : dacc_store_if

// >>> test/dacc_exec.sv
// Purpose: execution side driving accumulator requests
// Assumes: one request set at a time, taken at the next edge
// Notes: write, read and multiply may be raised together
`timescale 1ns/10ps
module dacc_exec
	import dacc_pkg::*;
(
	input wire logic clk_sys,
	output logic wr_en,
	output logic wr_acc_sel,
	output dacc_wr_op_t wr_op,
	output logic [SLICE_W-1:0] wr_data,
	output logic rd_en,
	output logic rd_acc_sel,
	output dacc_rd_op_t rd_op,
	output logic mul_en,
	output dacc_mul_op_t mul_op,
	output logic [ACC_STORED_W-1:0] mul_result
);
	// quiet from time zero
	initial begin
		{wr_en, rd_en, mul_en, wr_acc_sel, rd_acc_sel} = '0;
		{wr_data, mul_result} = '0;
		wr_op = acc_low_write_op;
		rd_op = acc_low_read_op;
		mul_op = plain_multiply_op;
	end
	// held through exactly one sampling edge
	task automatic op(input logic w, s, input dacc_wr_op_t wo,
		input logic [31:0] d, input logic r, rs, input dacc_rd_op_t ro,
		input logic mu, input dacc_mul_op_t mo, input logic [71:0] mr);
		@(posedge clk_sys);
		#1;
		{wr_en, wr_acc_sel, wr_data, rd_en, rd_acc_sel} = {w, s, d, r, rs};
		{mul_en, mul_result} = {mu, mr};
		wr_op = wo;
		rd_op = ro;
		mul_op = mo;
		@(posedge clk_sys);
		#1;
		{wr_en, rd_en, mul_en} = '0;
		// released data must not look like held data
		{wr_data, mul_result} = ~{wr_data, mul_result};
	endtask : op
endmodule : dacc_exec

// >>> test/dacc_sva.sv
// Purpose: port checks for the accumulator pair
// Assumes: one clock, rst async active high
// Notes: bound to the top, watches request inputs and outputs
`timescale 1ns/10ps
module dacc_sva
	import dacc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic wr_acc_sel,
	input wire dacc_wr_op_t wr_op,
	input wire logic [SLICE_W-1:0] wr_data,
	input wire logic rd_en,
	input wire logic rd_acc_sel,
	input wire dacc_rd_op_t rd_op,
	input wire logic [SLICE_W-1:0] rd_data,
	input wire logic rd_valid,
	input wire logic mul_en,
	input wire dacc_mul_op_t mul_op,
	input wire logic [ACC_STORED_W-1:0] mul_result,
	input wire logic [ACC_VIEW_W-1:0] acc_zero_view,
	input wire logic [ACC_VIEW_W-1:0] acc_one_view
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	valid_pulse_a: assert property (rd_valid == $past(rd_en))
		else $error("rd_valid off");
	sign_copy_a: assert property (acc_zero_view[95:72] ==
		{EXT_W{acc_zero_view[71]}} && acc_one_view[95:72] ==
		{EXT_W{acc_one_view[71]}}) else $error("no sign copy");
	mul_load_a: assert property (mul_en && $onehot(mul_op) |=>
		acc_zero_view[71:0] == $past(mul_result)) else $error("mul load");
	one_kept_a: assert property (!(wr_en && wr_acc_sel) |=>
		$stable(acc_one_view)) else $error("acc one moved");
	low_load_a: assert property (wr_en && wr_acc_sel &&
		wr_op == acc_low_write_op |=> acc_one_view[31:0] == $past(wr_data))
		else $error("low load");
	slice_keep_a: assert property (wr_en && wr_acc_sel &&
		wr_op == acc_low_write_op |=> $stable(acc_one_view[95:32]))
		else $error("slice spill");
	guard_drop_a: assert property (wr_en && !wr_acc_sel && !mul_en &&
		wr_op == acc_guard_write_op |=> acc_zero_view[71:64] ==
		$past(wr_data[7:0])) else $error("guard load");
	mid_read_a: assert property (rd_en && rd_acc_sel &&
		rd_op == acc_middle_read_op |=> rd_data == $past(acc_one_view[47:16]))
		else $error("middle read");
endmodule : dacc_sva
bind dacc_pair dacc_sva dacc_sva_inst (.*);

// >>> test/tb.sv
// Purpose: directed bench for the accumulator pair
// Assumes: the exec model issues every request
// Notes: a shadow of both slots gives each expectation
`timescale 1ns/10ps
module tb;
	import dacc_pkg::*;
	logic clk_sys, rst, wr_en, wr_acc_sel, rd_en, rd_acc_sel, rd_valid, mul_en;
	dacc_wr_op_t wr_op;
	dacc_rd_op_t rd_op;
	dacc_mul_op_t mul_op;
	logic [31:0] wr_data, rd_data;
	logic [71:0] mul_result, m[2];
	logic [95:0] acc_zero_view, acc_one_view, e;
	int num_errors, n_checks;
	dacc_rd_op_t ro[4] = '{acc_guard_read_op, acc_high_read_op,
		acc_middle_read_op, acc_low_read_op};
	dacc_pair dacc_pair_inst (.*);
	dacc_exec dacc_exec_inst (.*);
	////////////////////////////////////////////////////////////////////
	function automatic logic [95:0] ext(input logic [71:0] v);
		return {{EXT_W{v[SIGN_BIT]}}, v};
	endfunction : ext
	task automatic chk(input logic [95:0] s, input logic [95:0] x);
		n_checks++;
		if (s !== x) begin
			num_errors++;
			$display("BAD %0t seen %h want %h", $time, s, x);
		end
	endtask : chk
	task automatic views;
		chk(acc_zero_view, ext(m[0]));
		chk(acc_one_view, ext(m[1]));
	endtask : views
	task automatic wr(input logic s, input dacc_wr_op_t o, input logic [31:0] d);
		dacc_exec_inst.op('1, s, o, d, '0, '0, ro[0], '0, mul_op, '0);
		// guard keeps only the byte that lands in stored bits
		case (o)
			acc_guard_write_op: m[s][71:64] = d[7:0];
			acc_high_write_op: m[s][63:32] = d;
			default: m[s][31:0] = d;
		endcase
		views;
	endtask : wr
	task automatic rd(input logic s, input int i);
		e = ext(m[s]);
		dacc_exec_inst.op('0, '0, wr_op, '0, '1, s, ro[i], '0, mul_op, '0);
		chk(rd_valid, 1);
		chk(rd_data, e[(i == 2) ? 47 : (i == 3) ? 31 : 95 - 32 * i -: 32]);
	endtask : rd
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////////
	// free-running core clock
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	// cut a hang short
	initial begin
		#20000;
		num_errors++;
		give_verdict();
	end
	// main sequence
	initial begin
		rst = 1;
		m = '{default: '0};
		repeat (4) @(posedge clk_sys);
		views;
		chk(rd_valid, 0);
		#1 rst = 0;
		for (int s = 0; s < 2; s++) begin
			wr(s[0], acc_guard_write_op, 32'hffff_ff80);
			wr(s[0], acc_high_write_op, 32'h1357_9bdf ^ s);
			wr(s[0], acc_low_write_op, 32'h2468_ace0 + s);
			for (int i = 0; i < 4; i++) rd(s[0], i);
			wr(s[0], acc_guard_write_op, 32'h0000_007f);
			rd(s[0], 0);
		end
		// every multiply kind overwrites the first slot only
		for (int i = 0; i < 5; i++) begin
			m[0] = {i[7:0] << 7, 64'h8000_0000_0000_0001};
			dacc_exec_inst.op('0, '0, wr_op, '0, '0, '0, ro[0], '1,
				dacc_mul_op_t'(5'h1 << i), m[0]);
			views;
		end
		// codes outside the one-hot sets change nothing; reads give 0
		dacc_exec_inst.op('1, '1, dacc_wr_op_t'(3'h3), '1, '1, '1,
			dacc_rd_op_t'(4'h3), '1, dacc_mul_op_t'(5'h3), '1);
		chk(rd_data, 0);
		views;
		// multiply while a write with the held illegal code 3'h3 is raised; a read sees the old value
		e = ext(m[0]);
		m[0] = 72'h5a;
		dacc_exec_inst.op('1, '0, wr_op, '1, '1, '0, ro[3], '1,
			float_multiply_op, m[0]);
		chk(rd_data, e[31:0]);
		views;
		rst = 1;
		m = '{default: '0};
		@(posedge clk_sys);
		views;
		chk(rd_data, 0);
		#1 rst = 0;
		// slot one must take writes and reads again after a mid-run reset
		wr(1'b1, acc_high_write_op, 32'hc0de_0001);
		rd(1'b1, 1);
		give_verdict();
	end
endmodule : tb
